// >>> hw/gpedg_regs.vh
// Register map, field layout and reset values of the pin edge detector.
// Included by the edge detector top; definitions only.
`ifndef GPEDG_REGS_VH
`define GPEDG_REGS_VH

// Pin count (width of the pin-backed registers) and bus address width
`define GPEDG_NPINS 28
`define GPEDG_ADDR_W 8

// Byte offsets of the registers on the bus
`define GPEDG_OFS_RISE 8'h10
`define GPEDG_OFS_FALL 8'h14
`define GPEDG_OFS_EDGE 8'h18
`define GPEDG_OFS_ISTAT 8'h20
`define GPEDG_OFS_IMASK 8'h24

// Split between individual and grouped pin requests
`define GPEDG_SOLO_TOP 10
`define GPEDG_GROUP_LOW 11

// Cycles after reset before the edge detector trusts its samples
`define GPEDG_ARM_WAIT 2'h3

// Reset values (pins 0 and 1 armed on both edges)
`define GPEDG_RST_RISE 28'h0000003
`define GPEDG_RST_FALL 28'h0000003
`define GPEDG_RST_EDGE 28'h0000000
`define GPEDG_RST_IMASK 2'h0
`define GPEDG_RST_ISTAT 2'h0

// Interrupt status field positions
`define GPEDG_IBIT_SOLO 0
`define GPEDG_IBIT_GROUP 1

// AXI response codes
`define GPEDG_RESP_OKAY 2'h0
`define GPEDG_RESP_SLVERR 2'h2

`endif

// >>> hw/gpedg_top.v
// Edge detector for 28 general-purpose pins with an AXI4-Lite register slave.
// Assumes the pins are asynchronous to aclk and the master keeps AXI4-Lite
// signalling; one write and one read at most are outstanding.
// Pins may rest high or low; nothing is reported until the sample pipe has
// refilled after reset, so pin changes in the first few cycles go unseen.
// Byte strobes are honoured on every register, the clearing write included.
`timescale 1ns/1ps
`include "gpedg_regs.vh"

module gpedg_top (
    input wire aclk, // System clock, 200 MHz
    input wire aresetn, // Synchronous reset, active low
    input wire [`GPEDG_NPINS-1:0] pin_in, // Asynchronous pin levels
    input wire [`GPEDG_ADDR_W-1:0] s_axi_awaddr, // Write address
    input wire [2:0] s_axi_awprot, // Write protection, unused
    input wire s_axi_awvalid, // Write address valid
    output reg s_axi_awready, // Write address ready
    input wire [31:0] s_axi_wdata, // Write data
    input wire [3:0] s_axi_wstrb, // Write byte strobes
    input wire s_axi_wvalid, // Write data valid
    output reg s_axi_wready, // Write data ready
    output reg [1:0] s_axi_bresp, // Write response
    output reg s_axi_bvalid, // Write response valid
    input wire s_axi_bready, // Write response ready
    input wire [`GPEDG_ADDR_W-1:0] s_axi_araddr, // Read address
    input wire [2:0] s_axi_arprot, // Read protection, unused
    input wire s_axi_arvalid, // Read address valid
    output reg s_axi_arready, // Read address ready
    output reg [31:0] s_axi_rdata, // Read data
    output reg [1:0] s_axi_rresp, // Read response
    output reg s_axi_rvalid, // Read data valid
    input wire s_axi_rready, // Read data ready
    output reg [`GPEDG_SOLO_TOP:0] irq_pin, // Per-pin requests, pins 10..0
    output reg irq_group, // Combined request, pins 27..11
    output reg irq // Masked summary interrupt
);

    // Register select codes, one-hot
    localparam [5:0] SEL_NONE = 6'h01;
    localparam [5:0] SEL_RISE = 6'h02;
    localparam [5:0] SEL_FALL = 6'h04;
    localparam [5:0] SEL_EDGE = 6'h08;
    localparam [5:0] SEL_ISTAT = 6'h10;
    localparam [5:0] SEL_IMASK = 6'h20;
    localparam NP = `GPEDG_NPINS;

    // Address decode, shared by the read and write paths
    function [5:0] reg_sel;
        input [`GPEDG_ADDR_W-1:0] a;
        begin
            case (a)
                `GPEDG_OFS_RISE: reg_sel = SEL_RISE;
                `GPEDG_OFS_FALL: reg_sel = SEL_FALL;
                `GPEDG_OFS_EDGE: reg_sel = SEL_EDGE;
                `GPEDG_OFS_ISTAT: reg_sel = SEL_ISTAT;
                `GPEDG_OFS_IMASK: reg_sel = SEL_IMASK;
                default: reg_sel = SEL_NONE;
            endcase
        end
    endfunction

    // Expand byte strobes to a bit mask over the pin-backed width
    function [NP-1:0] lane_mask;
        input [3:0] s;
        begin
            lane_mask = {{4{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
        end
    endfunction

    // Byte-lane merge of a write into a register image
    function [NP-1:0] lane_merge;
        input [NP-1:0] old;
        input [NP-1:0] upd;
        input [NP-1:0] m;
        begin
            lane_merge = (old & ~m) | (upd & m);
        end
    endfunction

    // Pin synchroniser, previous sample and detector state
    reg [NP-1:0] pin_meta;
    reg [NP-1:0] pin_sync;
    reg [NP-1:0] pin_prev;
    reg [1:0] arm_cnt;
    wire armed;
    wire [NP-1:0] edge_hit;
    wire [NP-1:0] edge_clr;
    wire [NP-1:0] next_edge_stat;

    // Software-visible registers
    reg [NP-1:0] rise_sel;
    reg [NP-1:0] fall_sel;
    reg [NP-1:0] edge_stat;
    reg [1:0] int_stat;
    reg [1:0] int_mask;

    // Write channel holding state
    reg aw_held;
    reg w_held;
    reg [`GPEDG_ADDR_W-1:0] awaddr_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;

    // Two flip-flops per pin before any logic looks at the level
    always @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta <= {NP{1'b0}};
            pin_sync <= {NP{1'b0}};
            pin_prev <= {NP{1'b0}};
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
            pin_prev <= pin_sync;
        end
    end

    // Detection off while the pipe refills; its reset zeros would
    // otherwise look like a rising edge on every pin resting high
    always @(posedge aclk) begin
        if (!aresetn) begin
            arm_cnt <= 2'h0;
        end else if (arm_cnt != `GPEDG_ARM_WAIT) begin
            arm_cnt <= arm_cnt + 2'h1;
        end
    end

    // Armed once the fill count is reached
    assign armed = (arm_cnt == `GPEDG_ARM_WAIT);

    // Per-pin edge qualification; idle until the first true sample pair
    genvar g;
    generate
        for (g = 0; g < NP; g = g + 1) begin : g_pin
            wire rose = pin_sync[g] & ~pin_prev[g];
            wire fell = ~pin_sync[g] & pin_prev[g];
            // Either select may qualify, zero blocks its kind
            assign edge_hit[g] = armed & ((rose & rise_sel[g]) | (fell & fall_sel[g]));
            // Set beats clear, so an edge during a clearing write is kept
            assign next_edge_stat[g] = (edge_stat[g] & ~edge_clr[g]) | edge_hit[g];
        end
    endgenerate

    // Write handshake and commit decision
    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take = s_axi_wvalid & s_axi_wready;
    wire aw_have = aw_held | aw_take;
    wire w_have = w_held | w_take;
    wire do_write = aw_have & w_have & ~s_axi_bvalid;
    wire [`GPEDG_ADDR_W-1:0] wr_addr = aw_held ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_held ? wdata_q : s_axi_wdata;
    wire [3:0] wr_strb = w_held ? wstrb_q : s_axi_wstrb;
    wire [5:0] wr_sel = do_write ? reg_sel(wr_addr) : 6'h00;
    wire [NP-1:0] wr_mask = lane_mask(wr_strb);
    wire next_aw_held = aw_have & ~do_write;
    wire next_w_held = w_have & ~do_write;
    wire next_bvalid = do_write | (s_axi_bvalid & ~s_axi_bready);

    // Read handshake
    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire [5:0] rd_sel = reg_sel(s_axi_araddr);
    wire next_rvalid = ar_take | (s_axi_rvalid & ~s_axi_rready);

    // Edge status: clear by writing one, but a fresh edge always wins
    assign edge_clr = (wr_sel == SEL_EDGE) ? (wr_data[NP-1:0] & wr_mask) : {NP{1'b0}};

    // Interrupt events: any new edge in the solo or grouped range
    wire [1:0] int_event = {|edge_hit[NP-1:`GPEDG_GROUP_LOW], |edge_hit[`GPEDG_SOLO_TOP:0]};

    // Reading the summary status clears it; a same-cycle event is kept
    wire istat_rd = ar_take & (rd_sel == SEL_ISTAT);
    wire [1:0] next_int_stat = (istat_rd ? 2'h0 : int_stat) | int_event;
    wire [1:0] next_int_mask = (wr_sel == SEL_IMASK) ?
        ((int_mask & ~wr_mask[1:0]) | (wr_data[1:0] & wr_mask[1:0])) : int_mask;

    // Request levels taken from the next status image
    wire [`GPEDG_SOLO_TOP:0] next_irq_pin = next_edge_stat[`GPEDG_SOLO_TOP:0];
    wire next_irq_group = |next_edge_stat[NP-1:`GPEDG_GROUP_LOW];
    wire next_irq = |(next_int_stat & next_int_mask);

    // Unmapped addresses answer with an error and change nothing
    wire [1:0] wr_resp = (wr_sel == SEL_NONE) ? `GPEDG_RESP_SLVERR : `GPEDG_RESP_OKAY;
    wire [1:0] rd_resp = (rd_sel == SEL_NONE) ? `GPEDG_RESP_SLVERR : `GPEDG_RESP_OKAY;

    // Read data mux; reserved bits and unmapped addresses read zero
    reg [31:0] rd_word;
    always @* begin
        rd_word = 32'h00000000;
        case (rd_sel)
            SEL_RISE: rd_word = {4'h0, rise_sel};
            SEL_FALL: rd_word = {4'h0, fall_sel};
            SEL_EDGE: rd_word = {4'h0, edge_stat};
            SEL_ISTAT: rd_word = {30'h0, int_stat};
            SEL_IMASK: rd_word = {30'h0, int_mask};
            default: rd_word = 32'h00000000;
        endcase
    end

    // Select registers with byte-lane writes; only bits 27..0 exist
    always @(posedge aclk) begin
        if (!aresetn) begin
            rise_sel <= `GPEDG_RST_RISE;
            fall_sel <= `GPEDG_RST_FALL;
        end else begin
            if (wr_sel == SEL_RISE) begin
                rise_sel <= lane_merge(rise_sel, wr_data[NP-1:0], wr_mask);
            end
            if (wr_sel == SEL_FALL) begin
                fall_sel <= lane_merge(fall_sel, wr_data[NP-1:0], wr_mask);
            end
        end
    end

    // Status bits and summary interrupt state
    always @(posedge aclk) begin
        if (!aresetn) begin
            edge_stat <= `GPEDG_RST_EDGE;
            int_stat <= `GPEDG_RST_ISTAT;
            int_mask <= `GPEDG_RST_IMASK;
        end else begin
            edge_stat <= next_edge_stat;
            int_stat <= next_int_stat;
            int_mask <= next_int_mask;
        end
    end

    // Request outputs register the next status so they rise with it
    always @(posedge aclk) begin
        if (!aresetn) begin
            irq_pin <= {(`GPEDG_SOLO_TOP+1){1'b0}};
            irq_group <= 1'b0;
            irq <= 1'b0;
        end else begin
            irq_pin <= next_irq_pin;
            irq_group <= next_irq_group;
            irq <= next_irq;
        end
    end

    // Write channel: capture address and data in either order
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            awaddr_q <= {`GPEDG_ADDR_W{1'b0}};
            wdata_q <= 32'h00000000;
            wstrb_q <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `GPEDG_RESP_OKAY;
        end else begin
            if (aw_take) begin
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            // Ready again only once the previous response has gone
            s_axi_awready <= ~next_aw_held & ~next_bvalid;
            s_axi_wready <= ~next_w_held & ~next_bvalid;
            s_axi_bvalid <= next_bvalid;
            if (do_write) begin
                s_axi_bresp <= wr_resp;
            end
        end
    end

    // Read channel: data registered one cycle after the address
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h00000000;
            s_axi_rresp <= `GPEDG_RESP_OKAY;
        end else begin
            s_axi_arready <= ~next_rvalid;
            s_axi_rvalid <= next_rvalid;
            if (ar_take) begin
                s_axi_rdata <= rd_word;
                s_axi_rresp <= rd_resp;
            end
        end
    end

endmodule // gpedg_top

// >>> testbench/gpedg_monitor.sv
// Port checks for the pin edge detector.
// Bound into gpedg_top; one clock domain, reset low.
`timescale 1ns/1ps
module gpedg_monitor (
    input wire aclk, // Clock
    input wire aresetn, // Reset
    input wire s_axi_awready, // AW ready
    input wire s_axi_wvalid, // W valid
    input wire s_axi_wready, // W ready
    input wire s_axi_awvalid, // AW valid
    input wire [1:0] s_axi_bresp, // B code
    input wire s_axi_bvalid, // B valid
    input wire s_axi_bready, // B ready
    input wire s_axi_arvalid, // AR valid
    input wire s_axi_arready, // AR ready
    input wire [31:0] s_axi_rdata, // R data
    input wire s_axi_rvalid, // R valid
    input wire s_axi_rready, // R ready
    input wire [10:0] irq_pin, // Pin requests
    input wire irq_group, // Group request
    input wire irq // Summary
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // Handshake timing
    chk_b_once: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid) else $error("b");
    chk_r_once: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid) else $error("r");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read late");
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write late");
    chk_w_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("w ready");
    chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("ar ready");
    // Register contents and sticky requests
    chk_reserved_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:28] == 4'h0)
        else $error("reserved bits");
    chk_pin_sticky: assert property (|(~irq_pin & $past(irq_pin)) |->
        $rose(s_axi_bvalid) || $past(!aresetn)) else $error("pin request lost");
    chk_group_sticky: assert property ($fell(irq_group) |->
        $rose(s_axi_bvalid) || $past(!aresetn)) else $error("group request lost");
    cover property (irq);
    cover property (irq_group);
    cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // gpedg_monitor

bind gpedg_top gpedg_monitor u_gpedg_monitor (.aclk, .aresetn, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_awvalid, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .irq_pin, .irq_group, .irq);

// >>> testbench/gpedg_pin_model.sv
// Behavioural stand-in for the 28 external pins.
// Levels change just after a rising edge of aclk.
`timescale 1ns/1ps
module gpedg_pin_model (
    input wire aclk, // System clock
    output logic [27:0] pin_in // Pin levels
);
    // Idle level at time zero
    initial pin_in = 28'h0;
    // New levels, then time for sync and latch
    task automatic drive(input logic [27:0] lvl);
        @(posedge aclk);
        pin_in <= lvl;
        repeat (6) @(posedge aclk);
    endtask
endmodule // gpedg_pin_model

// >>> testbench/gpedg_top_tb.sv
// Self-checking bench for the pin edge detector.
// Assumes gpedg_top, the pin model and the checker compile alongside.
`timescale 1ns/1ps
`include "gpedg_regs.vh"
module gpedg_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq_group, irq;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [3:0] s_axi_wstrb;
    logic [2:0] s_axi_awprot, s_axi_arprot;
    logic [10:0] irq_pin;
    logic [27:0] pin_in;
    integer n_errors, n_compared;
    localparam logic [7:0] a_ri = `GPEDG_OFS_RISE, a_fa = `GPEDG_OFS_FALL, a_ed = `GPEDG_OFS_EDGE;
    localparam logic [7:0] a_is = `GPEDG_OFS_ISTAT, a_im = `GPEDG_OFS_IMASK;
    gpedg_pin_model u_pins (.aclk, .pin_in);
    gpedg_top u_gpedg_top (.aclk, .aresetn, .pin_in, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .irq_pin, .irq_group, .irq);
    // Clock, 5 ns period
    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", {30'h0, s_axi_bresp}, {30'h0, er});
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rdata", s_axi_rdata, ed);
        chk("rresp", {30'h0, s_axi_rresp}, {30'h0, er});
    endtask
    // Request lines as one word: summary, group, pins 10..0
    task automatic irqs(input logic [31:0] exp);
        @(posedge aclk);
        chk("irq", {19'h0, irq, irq_group, irq_pin}, exp);
    endtask
    task automatic conclude;
        $display("compared %0d errors %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        conclude();
    end
    // Main sequence
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        {s_axi_wstrb, s_axi_awprot, s_axi_arprot} = 10'h3c0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
        aresetn = 1'b0;
        n_errors = 0;
        n_compared = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(a_ri, 32'h3, 2'h0);
        rd(a_fa, 32'h3, 2'h0);
        rd(a_ed, 32'h0, 2'h0);
        rd(a_im, 32'h0, 2'h0);
        rd(8'h1c, 32'h0, 2'h2);
        wr(8'h30, 32'hffffffff, 2'h2);
        wr(a_ri, 32'hffffffff, 2'h0);
        rd(a_ri, 32'h0fffffff, 2'h0);
        wr(a_fa, 32'h0, 2'h0);
        u_pins.drive(28'hfffffff);
        rd(a_ed, 32'h0fffffff, 2'h0);
        irqs(32'hfff);
        u_pins.drive(28'h0);
        wr(a_ed, 32'h0, 2'h0);
        rd(a_ed, 32'h0fffffff, 2'h0);
        wr(a_ed, 32'h0ffff7ff, 2'h0);
        rd(a_ed, 32'h800, 2'h0);
        irqs(32'h800);
        wr(a_ed, 32'h800, 2'h0);
        irqs(32'h0);
        // Protection bits are ignored from here on
        {s_axi_awprot, s_axi_arprot} <= 6'h3f;
        // Falling only
        wr(a_ri, 32'h0, 2'h0);
        wr(a_fa, 32'h0fffffff, 2'h0);
        u_pins.drive(28'hfffffff);
        rd(a_ed, 32'h0, 2'h0);
        u_pins.drive(28'h0);
        rd(a_ed, 32'h0fffffff, 2'h0);
        // Clear through byte lane 0 only
        s_axi_wstrb <= 4'h1;
        wr(a_ed, 32'hffffffff, 2'h0);
        rd(a_ed, 32'h0fffff00, 2'h0);
        s_axi_wstrb <= 4'hf;
        wr(a_ed, 32'hffffffff, 2'h0);
        // Both edges on pin 5
        wr(a_ri, 32'h20, 2'h0);
        wr(a_fa, 32'h20, 2'h0);
        u_pins.drive(28'h20);
        rd(a_ed, 32'h20, 2'h0);
        wr(a_ed, 32'h20, 2'h0);
        u_pins.drive(28'h0);
        rd(a_ed, 32'h20, 2'h0);
        wr(a_ed, 32'h20, 2'h0);
        // Summary interrupt: masked, unmasked, read-clear
        rd(a_is, 32'h3, 2'h0);
        rd(a_is, 32'h0, 2'h0);
        u_pins.drive(28'h20);
        irqs(32'h20);
        wr(a_im, 32'h1, 2'h0);
        irqs(32'h1020);
        rd(a_is, 32'h1, 2'h0);
        irqs(32'h20);
        conclude();
    end
endmodule // gpedg_top_tb
